/* File: pkg/acq_map.svh */
`ifndef ACQ_MAP_SVH
`define ACQ_MAP_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define ACQ_CLK_PERIOD_NS 50
`define ACQ_INT_OSC_PERIOD_NS 200
`define ACQ_INT_OSC_DIV (`ACQ_INT_OSC_PERIOD_NS / `ACQ_CLK_PERIOD_NS)
`define ACQ_CONV_TICKS 14
`define ACQ_EOC_PULSE_NS 100
`define ACQ_EOC_CLKS ((`ACQ_EOC_PULSE_NS + `ACQ_CLK_PERIOD_NS - 1) / `ACQ_CLK_PERIOD_NS)

// ----------------------------------------------------------------
// Field positions in the synchronised pin vector
// ----------------------------------------------------------------
`define ACQ_PIN_WIDTH 16
`define ACQ_PIN_DIN_LO 0
`define ACQ_PIN_DIN_HI 3
`define ACQ_PIN_PICK_LO 4
`define ACQ_PIN_PICK_HI 7
`define ACQ_PIN_SEQSRC 8
`define ACQ_PIN_WR 9
`define ACQ_PIN_RD 10
`define ACQ_PIN_CS 11
`define ACQ_PIN_TRIG 12
`define ACQ_PIN_CONVCLK 13
`define ACQ_PIN_CLKSRC 14
`define ACQ_PIN_LOW_POWER_HOLD_N 15

// ----------------------------------------------------------------
// Reset values and result slot count
// ----------------------------------------------------------------
`define ACQ_PIN_IDLE 16'h9E00
`define ACQ_CHSEL_RESET 4'hF
`define ACQ_SLOTS 4

`endif

/* File: pkg/acq_pkg.sv */
`include "acq_map.svh"

package acq_pkg;
    // Sequencer states, one-hot
    typedef enum logic [2:0] {
        ACQ_IDLE = 3'b001,
        ACQ_CONV = 3'b010,
        ACQ_EOC = 3'b100
    } acq_state_t;

    typedef logic [`ACQ_PIN_WIDTH-1:0] acq_pins_t;

    // Whole state of the control core
    typedef struct packed {
        acq_pins_t s1;
        acq_pins_t s2;
        acq_pins_t s3;
        acq_pins_t flt;
        acq_pins_t fltPrev;
        acq_state_t state;
        logic [3:0] chanSel;
        logic [3:0] mask;
        logic [1:0] chan;
        logic [1:0] slot;
        logic [1:0] rdPtr;
        logic [2:0] resCount;
        logic [1:0] divCnt;
        logic [3:0] tickCnt;
        logic [1:0] eocCnt;
        logic busy;
        logic eocN;
        logic hold;
        logic powerSave;
        logic dataOe;
        logic [11:0] dataOut;
        logic memWr;
        logic [1:0] memAddr;
        logic [11:0] memData;
    } acq_core_t;

    // Whole state of the result store
    typedef struct packed {
        logic [`ACQ_SLOTS-1:0][11:0] cells;
        logic [11:0] rdData;
    } acq_mem_t;
endpackage : acq_pkg

/* File: pkg/acq_mem_if.sv */
interface acq_mem_if;
    logic wrEn;
    logic [1:0] wrAddr;
    logic [11:0] wrData;
    logic [1:0] rdAddr;
    logic [11:0] rdData;

    modport ctrl (output wrEn, output wrAddr, output wrData, output rdAddr, input rdData);
    modport mem (input wrEn, input wrAddr, input wrData, input rdAddr, output rdData);
endinterface : acq_mem_if

/* File: src/acq_result_mem.sv */
module acq_result_mem
    import acq_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    acq_mem_if.mem port
);
    acq_mem_t r;
    acq_mem_t n;

    // ------------------------------------------------------------
    // Store and registered read
    // ------------------------------------------------------------
    // Read data is registered, so the host port sees one cycle of latency
    always_comb begin
        n = r;
        if (port.wrEn) begin
            n.cells[port.wrAddr] = port.wrData;
        end
        n.rdData = r.cells[port.rdAddr];
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign port.rdData = r.rdData;
endmodule : acq_result_mem

/* File: src/acq_host_port.sv */
`include "acq_map.svh"

// Behaviour
// - With the standby input high the block runs, with it low it sits in power save.
// - Clock source low ticks conversions from the internal divider, high from the clock pin.
// - A channel conversion takes fourteen conversion clocks before its result and end pulse.
// - Results leave on twelve three-state lines, line 11 most significant, floating unless read.
// - Bipolar variants give two's complement and the unipolar variant straight binary.
// - The low four data lines drive on reads and are driven by the host on chip-selected writes.
// - Channel-select bit 0 enables channel 1 up to bit 3 for channel 4.
// - Each finished conversion pulses the end-of-conversion line low briefly; it idles high.
// - A rising trigger edge holds all channels, latches the selection and starts converting.
// - Busy rises on the trigger edge and stays high until all selected channels are done.
// - A rising write strobe with chip select low and read high loads the low four lines.
// - Sequence source low takes the selection from the hardware pins, high from the register.
module acq_host_port
    import acq_pkg::*;
#(
    parameter bit UNIPOLAR_RANGE = 1'b0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic lowPowerHoldN,
    input wire logic clockSourceSelect,
    input wire logic conversionClockIn,
    input wire logic sampleTriggerN,
    input wire logic chipSelectN,
    input wire logic readStrobeN,
    input wire logic writeStrobeN,
    input wire logic sequenceSourceSelect,
    input wire logic [3:0] hwChannelPick,
    input wire logic [3:0] parallelDataLinesIn,
    input wire logic [11:0] sarCode,
    output logic [11:0] parallelDataLinesOut,
    output logic parallelDataLinesOe,
    output logic busy,
    output logic endOfConvN,
    output logic trackHold,
    output logic [1:0] convChannel,
    output logic powerSave
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Lowest enabled channel goes first; used at start and after each result
    function automatic logic [1:0] firstChan(input logic [3:0] m);
        logic [1:0] c;
        c = 2'h0;
        for (int i = 3; i >= 0; i--) begin
            if (m[i]) begin
                c = 2'(i);
            end
        end
        return c;
    endfunction : firstChan

    // Raw code from the converter core is offset binary
    function automatic logic [11:0] codeOut(input logic [11:0] raw);
        return UNIPOLAR_RANGE ? raw : {~raw[11], raw[10:0]};
    endfunction : codeOut

    acq_core_t r;
    acq_core_t n;
    acq_pins_t pinVec;
    acq_pins_t rise;
    logic intTick;
    logic convTick;
    logic [3:0] selMask;
    logic [2:0] ptrNext;

    acq_mem_if memIf ();

    acq_result_mem u_mem (
        .clk(clk),
        .rst(rst),
        .port(memIf.mem)
    );

    assign pinVec = {lowPowerHoldN, clockSourceSelect, conversionClockIn, sampleTriggerN,
                     chipSelectN, readStrobeN, writeStrobeN, sequenceSourceSelect,
                     hwChannelPick, parallelDataLinesIn};

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        n = r;
        n.memWr = 1'b0;
        // Three-stage sync; a change counts only when stages two and three agree
        n.s1 = pinVec;
        n.s2 = r.s1;
        n.s3 = r.s2;
        n.flt = (r.s3 & ~(r.s2 ^ r.s3)) | (r.flt & (r.s2 ^ r.s3));
        n.fltPrev = r.flt;
        rise = r.flt & ~r.fltPrev;

        // Internal oscillator stand-in: free-running divider
        intTick = (r.divCnt == 2'(`ACQ_INT_OSC_DIV - 1));
        n.divCnt = intTick ? 2'h0 : r.divCnt + 2'h1;
        convTick = r.flt[`ACQ_PIN_CLKSRC] ? rise[`ACQ_PIN_CONVCLK] : intTick;

        n.powerSave = ~r.flt[`ACQ_PIN_LOW_POWER_HOLD_N];
        selMask = r.flt[`ACQ_PIN_SEQSRC] ? r.chanSel
                                         : r.flt[`ACQ_PIN_PICK_HI:`ACQ_PIN_PICK_LO];

        // Host read: drive all twelve lines only while selected and reading
        n.dataOe = ~r.flt[`ACQ_PIN_CS] & ~r.flt[`ACQ_PIN_RD];
        n.dataOut = memIf.rdData;
        ptrNext = {1'b0, r.rdPtr} + 3'h1;
        if (rise[`ACQ_PIN_RD] && !r.flt[`ACQ_PIN_CS]) begin
            n.rdPtr = (ptrNext >= r.resCount) ? 2'h0 : ptrNext[1:0];
        end

        // Host write: bit i enables channel i+1
        if (rise[`ACQ_PIN_WR] && !r.flt[`ACQ_PIN_CS] && r.flt[`ACQ_PIN_RD]) begin
            n.chanSel = r.flt[`ACQ_PIN_DIN_HI:`ACQ_PIN_DIN_LO];
        end

        case (r.state)
            ACQ_IDLE: begin
                // Standby and an empty selection both refuse a start
                if (rise[`ACQ_PIN_TRIG] && r.flt[`ACQ_PIN_LOW_POWER_HOLD_N] && selMask != 4'h0) begin
                    n.state = ACQ_CONV;
                    n.busy = 1'b1;
                    n.hold = 1'b1;
                    n.mask = selMask;
                    n.chan = firstChan(selMask);
                    n.tickCnt = 4'h0;
                    n.slot = 2'h0;
                    n.resCount = 3'h0;
                    n.rdPtr = 2'h0;
                end
            end
            ACQ_CONV: begin
                if (convTick) begin
                    if (r.tickCnt == 4'(`ACQ_CONV_TICKS - 1)) begin
                        n.state = ACQ_EOC;
                        n.eocN = 1'b0;
                        n.eocCnt = 2'h0;
                        n.memWr = 1'b1;
                        n.memAddr = r.slot;
                        n.memData = codeOut(sarCode);
                        n.mask[r.chan] = 1'b0;
                        n.slot = r.slot + 2'h1;
                        n.resCount = r.resCount + 3'h1;
                    end else begin
                        n.tickCnt = r.tickCnt + 4'h1;
                    end
                end
            end
            ACQ_EOC: begin
                n.eocCnt = r.eocCnt + 2'h1;
                if (r.eocCnt == 2'(`ACQ_EOC_CLKS - 1)) begin
                    n.eocN = 1'b1;
                    n.tickCnt = 4'h0;
                    n.chan = firstChan(r.mask);
                    if (r.mask == 4'h0) begin
                        n.state = ACQ_IDLE;
                        n.busy = 1'b0;
                        n.hold = 1'b0;
                    end else begin
                        n.state = ACQ_CONV;
                    end
                end
            end
            default: begin
                n.state = ACQ_IDLE;
                n.busy = 1'b0;
                n.hold = 1'b0;
                n.eocN = 1'b1;
            end
        endcase
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r <= '0;
            r.s1 <= `ACQ_PIN_IDLE;
            r.s2 <= `ACQ_PIN_IDLE;
            r.s3 <= `ACQ_PIN_IDLE;
            r.flt <= `ACQ_PIN_IDLE;
            r.fltPrev <= `ACQ_PIN_IDLE;
            r.state <= ACQ_IDLE;
            r.chanSel <= `ACQ_CHSEL_RESET;
            r.eocN <= 1'b1;
        end else begin
            r <= n;
        end
    end

    // Outputs and store port, all from flops
    assign memIf.wrEn = r.memWr;
    assign memIf.wrAddr = r.memAddr;
    assign memIf.wrData = r.memData;
    assign memIf.rdAddr = r.rdPtr;
    assign parallelDataLinesOut = r.dataOut;
    assign parallelDataLinesOe = r.dataOe;
    assign busy = r.busy;
    assign endOfConvN = r.eocN;
    assign trackHold = r.hold;
    assign convChannel = r.chan;
    assign powerSave = r.powerSave;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_standby_blocks: assert property (@(posedge clk) disable iff (rst)
        (r.state == ACQ_IDLE && !r.flt[`ACQ_PIN_LOW_POWER_HOLD_N]) |=> (r.state == ACQ_IDLE && !r.busy))
        else $error("start taken while in standby");

    chk_ext_clock_pace: assert property (@(posedge clk) disable iff (rst)
        (r.state == ACQ_CONV && r.flt[`ACQ_PIN_CLKSRC] && !rise[`ACQ_PIN_CONVCLK])
        |=> $stable(r.tickCnt))
        else $error("conversion advanced without external clock edge");

    chk_fourteen_ticks: assert property (@(posedge clk) disable iff (rst)
        $fell(r.eocN) |-> ($past(r.tickCnt) == 4'(`ACQ_CONV_TICKS - 1) && $past(convTick)))
        else $error("end pulse not after fourteen clocks");

    chk_bus_floats: assert property (@(posedge clk) disable iff (rst)
        (r.flt[`ACQ_PIN_CS] || r.flt[`ACQ_PIN_RD]) |=> !parallelDataLinesOe)
        else $error("data lines driven without read");

    chk_result_coding: assert property (@(posedge clk) disable iff (rst)
        r.memWr |-> (r.memData[10:0] == $past(sarCode[10:0])
                     && r.memData[11] == ($past(sarCode[11]) ^ ~UNIPOLAR_RANGE)))
        else $error("stored result wrongly coded");

    chk_write_capture: assert property (@(posedge clk) disable iff (rst)
        (rise[`ACQ_PIN_WR] && !r.flt[`ACQ_PIN_CS] && r.flt[`ACQ_PIN_RD])
        |=> r.chanSel == $past(r.flt[`ACQ_PIN_DIN_HI:`ACQ_PIN_DIN_LO]))
        else $error("channel select not captured");

    chk_eoc_pulse: assert property (@(posedge clk) disable iff (rst)
        $fell(r.eocN) |=> !r.eocN ##1 r.eocN)
        else $error("end pulse width wrong");

    chk_busy_start: assert property (@(posedge clk) disable iff (rst)
        (r.state == ACQ_IDLE && rise[`ACQ_PIN_TRIG] && r.flt[`ACQ_PIN_LOW_POWER_HOLD_N] && selMask != 4'h0)
        |=> (r.busy && r.hold && r.mask == $past(selMask)))
        else $error("start did not raise busy and hold");

    chk_busy_end: assert property (@(posedge clk) disable iff (rst)
        $fell(r.busy) |-> ($past(r.state) == ACQ_EOC && $past(r.mask) == 4'h0))
        else $error("busy fell with channels left");

    chk_seq_source: assert property (@(posedge clk) disable iff (rst)
        (r.state == ACQ_IDLE && !r.flt[`ACQ_PIN_SEQSRC] && rise[`ACQ_PIN_TRIG]
         && r.flt[`ACQ_PIN_LOW_POWER_HOLD_N] && selMask != 4'h0)
        |=> r.mask == $past(r.flt[`ACQ_PIN_PICK_HI:`ACQ_PIN_PICK_LO]))
        else $error("hardware selection not used");
endmodule : acq_host_port

/* File: verification/acq_host_model.sv */
module acq_host_model #(
    parameter int HALF_NS = 400
) (
    input wire logic clk,
    input wire logic extRun,
    input wire logic devOe,
    input wire logic [3:0] devData,
    input wire logic hostOe,
    input wire logic [3:0] hostData,
    output logic [3:0] lowLines,
    output logic convClk
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] lastLevel = 4'h5;

    // ----------------------------------------------------------------
    // Low data lines
    // ----------------------------------------------------------------
    // A released bus keeps changing, so a stale value cannot pass for data
    always_comb begin
        if (devOe) begin
            lowLines = devData;
        end else if (hostOe) begin
            lowLines = hostData;
        end else begin
            lowLines = ~lastLevel;
        end
    end

    always_ff @(posedge clk) begin
        lastLevel <= lowLines;
    end

    // ----------------------------------------------------------------
    // External conversion clock
    // ----------------------------------------------------------------
    // Balanced phases; held low when the host is not running it
    initial convClk = 1'b0;
    always begin
        #(HALF_NS);
        convClk = extRun ? ~convClk : 1'b0;
    end
endmodule : acq_host_model

/* File: verification/test_acq_host_port.sv */
module test_acq_host_port;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic stbyN = 1'b1, clkSrc = 1'b0, extRun = 1'b0, trigN = 1'b1;
    logic csN = 1'b1, rdN = 1'b1, wrN = 1'b1, seqSrc = 1'b0, hostOe = 1'b0;
    logic [3:0] pick = 4'h0, hostData = 4'h0, linesIn;
    logic [11:0] sarCode = 12'h000, dataOut, uniOut;
    logic dataOe, busy, eocN, hold, pSave, convClk;
    logic [1:0] convCh;
    int failures = 0;
    int checked = 0;

    always #25 clk = ~clk;

    acq_host_port dut (.clk(clk), .rst(rst), .lowPowerHoldN(stbyN),
        .clockSourceSelect(clkSrc), .conversionClockIn(convClk), .sampleTriggerN(trigN),
        .chipSelectN(csN), .readStrobeN(rdN), .writeStrobeN(wrN),
        .sequenceSourceSelect(seqSrc), .hwChannelPick(pick), .parallelDataLinesIn(linesIn),
        .sarCode(sarCode), .parallelDataLinesOut(dataOut), .parallelDataLinesOe(dataOe),
        .busy(busy), .endOfConvN(eocN), .trackHold(hold), .convChannel(convCh),
        .powerSave(pSave));

    // Unipolar twin on the same pins; only its result word is watched
    acq_host_port #(.UNIPOLAR_RANGE(1'b1)) dutUni (.clk(clk), .rst(rst),
        .lowPowerHoldN(stbyN), .clockSourceSelect(clkSrc), .conversionClockIn(convClk),
        .sampleTriggerN(trigN), .chipSelectN(csN), .readStrobeN(rdN), .writeStrobeN(wrN),
        .sequenceSourceSelect(seqSrc), .hwChannelPick(pick), .parallelDataLinesIn(linesIn),
        .sarCode(sarCode), .parallelDataLinesOut(uniOut), .parallelDataLinesOe(),
        .busy(), .endOfConvN(), .trackHold(), .convChannel(), .powerSave());

    acq_host_model host (.clk(clk), .extRun(extRun), .devOe(dataOe),
        .devData(dataOut[3:0]), .hostOe(hostOe), .hostData(hostData),
        .lowLines(linesIn), .convClk(convClk));

    // Analog stand-in: the code names the channel being sampled
    always @(negedge clk) sarCode <= 12'hA50 + {10'h000, convCh};

    // ----------------------------------------------------------------
    // Checking and host bus tasks
    // ----------------------------------------------------------------
    task automatic close_out();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out

    task automatic cmp_w(input logic [11:0] got, input logic [11:0] exp, input string msg);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : cmp_w

    task automatic cmp_n(input int got, input int lo, input int hi, input string msg);
        checked++;
        if (got < lo || got > hi) begin
            failures++;
            $display("unexpected at %0t: %s got %0d", $time, msg, got);
        end
    endtask : cmp_n

    // Each strobe phase spans 8 clocks, twice the pin filter delay
    task automatic wr_sel(input logic [3:0] d, input logic cs);
        hostData = d;
        hostOe = 1'b1;
        csN = cs;
        wrN = 1'b0;
        repeat (8) @(negedge clk);
        wrN = 1'b1;
        repeat (8) @(negedge clk);
        csN = 1'b1;
        hostOe = 1'b0;
        // Let an edge pass so a following call never re-drives in the same step
        @(negedge clk);
    endtask : wr_sel

    // Read strobe rises before chip select so the pointer advances
    task automatic rd_word(input logic [11:0] exp);
        csN = 1'b0;
        rdN = 1'b0;
        repeat (8) @(negedge clk);
        cmp_w({11'h000, dataOe}, 12'h001, "drive on read");
        cmp_w(dataOut, exp, "result word");
        // Straight binary keeps the raw sign bit that two's complement flips
        cmp_w(uniOut, exp ^ 12'h800, "straight binary");
        rdN = 1'b1;
        repeat (8) @(negedge clk);
        csN = 1'b1;
        repeat (8) @(negedge clk);
        cmp_w({11'h000, dataOe}, 12'h000, "float after read");
    endtask : rd_word

    // Start a sequence, then change the pin pick to prove it was latched
    task automatic conv_seq(input logic [3:0] expMask, input int tick, input logic [3:0] newPick);
        int n;
        int k;
        int pulses;
        int lowClks;
        logic prevEoc;
        n = 8;
        k = 0;
        pulses = 0;
        lowClks = 0;
        prevEoc = 1'b1;
        trigN = 1'b0;
        repeat (8) @(negedge clk);
        trigN = 1'b1;
        repeat (8) @(negedge clk);
        cmp_w({11'h000, busy}, {11'h000, expMask != 4'h0}, "busy on start");
        cmp_w({11'h000, hold}, {11'h000, expMask != 4'h0}, "hold on start");
        pick = newPick;
        while (busy === 1'b1 && n < 4000) begin
            @(negedge clk);
            n++;
            if (eocN === 1'b0) begin
                lowClks++;
            end
            if (prevEoc === 1'b1 && eocN === 1'b0) begin
                while (k < 3 && !expMask[k]) k++;
                cmp_w({10'h000, convCh}, 12'(k), "channel order");
                if (pulses == 0) begin
                    cmp_n(n, 13 * tick, 15 * tick + 12, "conversion length");
                end
                pulses++;
                k++;
            end
            prevEoc = eocN;
        end
        if (n >= 4000) begin
            failures++;
            close_out();
        end
        cmp_n(pulses, $countones(expMask), $countones(expMask), "end pulses");
        cmp_n(lowClks, 2 * pulses, 2 * pulses, "pulse width");
        cmp_w({11'h000, eocN}, 12'h001, "end line idle");
    endtask : conv_seq

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (3) @(negedge clk);
        rst = 1'b0;
        repeat (2) @(negedge clk);
        cmp_w({7'h00, dataOe, busy, eocN, hold, pSave}, 12'h004, "reset state");
        // Register at reset value picks all four channels
        seqSrc = 1'b1;
        conv_seq(4'hF, 4, 4'h0);
        for (int i = 0; i < 4; i++) begin
            rd_word(12'h250 + 12'(i));
        end
        // Pin pick, latched at start
        seqSrc = 1'b0;
        pick = 4'hA;
        conv_seq(4'hA, 4, 4'hF);
        rd_word(12'h251);
        rd_word(12'h253);
        // Register writes; one with chip select high is ignored
        seqSrc = 1'b1;
        wr_sel(4'h1, 1'b0);
        wr_sel(4'h8, 1'b1);
        conv_seq(4'h1, 4, 4'hF);
        rd_word(12'h250);
        // Empty selection is refused
        wr_sel(4'h0, 1'b0);
        conv_seq(4'h0, 4, 4'hF);
        // External conversion clock, slower tick
        wr_sel(4'h8, 1'b0);
        clkSrc = 1'b1;
        extRun = 1'b1;
        conv_seq(4'h8, 16, 4'hF);
        extRun = 1'b0;
        clkSrc = 1'b0;
        rd_word(12'h253);
        // Standby blocks a start, normal run resumes after
        stbyN = 1'b0;
        repeat (8) @(negedge clk);
        cmp_w({11'h000, pSave}, 12'h001, "power save");
        conv_seq(4'h0, 4, 4'hF);
        stbyN = 1'b1;
        repeat (8) @(negedge clk);
        cmp_w({11'h000, pSave}, 12'h000, "awake");
        conv_seq(4'h8, 4, 4'hF);
        close_out();
    end
endmodule : test_acq_host_port
